// file: bsc_exec.sv
// execution of the bit-test skip and the subroutine call
`timescale 1ns/100ps
`include "bsc_map.svh"
module bsc_exec
#(
	parameter int PC_W   = 11,
	parameter int WORD_W = 12,
	parameter int DATA_W = 8
)
(
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire logic [WORD_W-1:0]  instr_i,
	input  wire logic               instr_valid_i,
	input  wire logic [DATA_W-1:0]  file_data_i,
	input  wire logic [DATA_W-1:0]  status_i,
	// the operand request and the return push each pulse for one cycle
	output bsc_pkg::bsc_fetch_t     file_req_o,
	output bsc_pkg::bsc_push_t      return_stack_top_o,
	output logic [PC_W-1:0]         pc_o,
	output logic                    flush_o,
	output logic                    busy_o
);

	logic                 rst_meta;
	logic                 rst_n;
	logic                 next_rst_meta;
	logic                 next_rst_n;

	bsc_pkg::bsc_state_t  state;
	bsc_pkg::bsc_state_t  next_state;
	logic                 flush;
	logic                 next_flush;
	logic [PC_W-1:0]      pc;
	logic [PC_W-1:0]      next_pc;
	bsc_pkg::bsc_push_t   push;
	bsc_pkg::bsc_push_t   next_push;
	bsc_pkg::bsc_fetch_t  freq;
	bsc_pkg::bsc_fetch_t  next_freq;

	// decoded view of the word in execute
	logic [3:0]           opcode;
	logic [4:0]           file_addr;
	logic [2:0]           bit_sel;
	logic                 bit_high;
	logic                 take;
	logic                 is_skip;
	logic                 is_call;
	logic                 skip_hit;

	// release is synchronised so every flop reset by rst_n leaves reset on the same edge
	always_comb
	begin
		next_rst_meta = 1'b1;
		next_rst_n    = rst_meta;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= next_rst_meta;
			rst_n    <= next_rst_n;
		end
	end

	// operand fields; file_data_i is the addressed register, read in the same cycle
	always_comb
	begin
		opcode    = instr_i[`BSC_OP_HI:`BSC_OP_LO];
		file_addr = instr_i[`BSC_FILE_HI:`BSC_FILE_LO];
		bit_sel   = instr_i[`BSC_BIT_HI:`BSC_BIT_LO];
		bit_high  = file_data_i[bit_sel];
		// a word offered in the flush cycle is the discarded prefetch
		take      = instr_valid_i && (state == bsc_pkg::BSC_EXEC);
		is_skip   = take && (opcode == `BSC_OP_SKIP_HIGH);
		is_call   = take && (opcode == `BSC_OP_CALL);
		skip_hit  = is_skip && bit_high;
	end

	// a taken skip or a call buys exactly one flush cycle, never two in a row
	always_comb
	begin
		next_state = bsc_pkg::BSC_EXEC;
		next_flush = 1'b0;
		case (state)
			bsc_pkg::BSC_EXEC:
			begin
				if (skip_hit || is_call)
				begin
					next_state = bsc_pkg::BSC_FLUSH;
					next_flush = 1'b1;
				end
			end
			bsc_pkg::BSC_FLUSH:
			begin
				// the fetched word runs as a no-operation
				next_state = bsc_pkg::BSC_EXEC;
			end
			default:
			begin
				// unused code: fall back to execute
				next_state = bsc_pkg::BSC_EXEC;
			end
		endcase
	end

	// flush is a registered copy of the flush state, so busy_o cannot glitch
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= bsc_pkg::BSC_EXEC;
			flush <= 1'b0;
		end
		else
		begin
			state <= next_state;
			flush <= next_flush;
		end
	end

	// program counter; status_i is only read, so no flag changes here
	always_comb
	begin
		next_pc = pc;
		if (is_call)
		begin
			// target page comes from status, its lower half is forced
			next_pc[`BSC_IMM_HI:`BSC_IMM_LO] = instr_i[`BSC_IMM_HI:`BSC_IMM_LO];
			next_pc[`BSC_PC_HALF] = 1'b0;
			next_pc[`BSC_PC_PAGE_HI:`BSC_PC_PAGE_LO] =
				status_i[`BSC_STAT_PAGE_HI:`BSC_STAT_PAGE_LO];
		end
		else if (skip_hit)
		begin
			// the discarded word is counted at once, so pc stands still in the flush
			next_pc = pc + `BSC_PC_SKIP;
		end
		else if (take)
		begin
			// an untaken skip and the words of other units just step
			next_pc = pc + `BSC_PC_STEP;
		end
	end

	// pc leaves reset at the reset vector
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pc <= `BSC_PC_RESET;
		end
		else
		begin
			pc <= next_pc;
		end
	end

	// return address leaves as a one-cycle pulse, the stack itself sits outside
	always_comb
	begin
		next_push = '0;
		if (is_call)
		begin
			next_push.valid = 1'b1;
			next_push.addr  = pc + `BSC_PC_STEP;
		end
	end

	// pulses default to zero, so each lasts exactly one cycle
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			push <= '0;
		end
		else
		begin
			push <= next_push;
		end
	end

	// operand request goes out for every executed bit test, taken or not
	always_comb
	begin
		next_freq = '0;
		if (is_skip)
		begin
			next_freq.valid   = 1'b1;
			next_freq.addr    = file_addr;
			next_freq.bit_sel = bit_sel;
		end
	end

	// request is registered, so it trails the tested word by one cycle
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			freq <= '0;
		end
		else
		begin
			freq <= next_freq;
		end
	end

	// busy mirrors flush so a fetch unit can stall without decoding state
	assign pc_o               = pc;
	assign return_stack_top_o = push;
	assign file_req_o         = freq;
	assign flush_o            = flush;
	assign busy_o             = flush;
endmodule

// file: bsc_map.svh
// constants for the bit-skip and call execution block
// Functional notes
// - opcode 0111 tests bit, skips when high
// - taken skip flushes prefetch, runs no-operation
// - file address 0..31, bit select 0..7
// - call pushes incremented program counter first
// - opcode 1001 loads immediate into pc low
// - status bits 6:5 copy to pc 10:9
// - call clears program counter bit 8
// - call takes two cycles, second flushes
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH
`define BSC_OP_HI          11
`define BSC_OP_LO          8
`define BSC_OP_SKIP_HIGH   4'h7
`define BSC_OP_CALL        4'h9
`define BSC_BIT_HI         7
`define BSC_BIT_LO         5
`define BSC_FILE_HI        4
`define BSC_FILE_LO        0
`define BSC_IMM_HI         7
`define BSC_IMM_LO         0
`define BSC_STAT_PAGE_HI   6
`define BSC_STAT_PAGE_LO   5
`define BSC_PC_PAGE_HI     10
`define BSC_PC_PAGE_LO     9
`define BSC_PC_HALF        8
`define BSC_PC_RESET       11'h000
`define BSC_PC_STEP        11'h001
`define BSC_PC_SKIP        11'h002
`define BSC_WORD_NOP       12'h000
`endif

// file: bsc_pkg.sv
// types for the bit-skip and call execution block
package bsc_pkg;
	typedef enum logic [1:0]
	{
		BSC_EXEC  = 2'b00,
		BSC_FLUSH = 2'b01
	} bsc_state_t;

	// one push toward the return stack
	typedef struct packed
	{
		logic        valid;
		logic [10:0] addr;
	} bsc_push_t;

	// operand fetch toward the file registers
	typedef struct packed
	{
		logic       valid;
		logic [4:0] addr;
		logic [2:0] bit_sel;
	} bsc_fetch_t;
endpackage

// file: bsc_exec_chk.sv
// assertions for the bit-skip and call block
`timescale 1ns/100ps
module bsc_exec_chk
(
	input logic                clk_i,
	input logic                reset_n_i,
	input logic [11:0]         instr_i,
	input logic                instr_valid_i,
	input logic [7:0]          file_data_i,
	input logic [7:0]          status_i,
	input bsc_pkg::bsc_fetch_t file_req_o,
	input bsc_pkg::bsc_push_t  return_stack_top_o,
	input logic [10:0]         pc_o,
	input logic                flush_o,
	input logic                busy_o
);
	// a word offered during the flush cycle is not taken
	wire tk = instr_valid_i & ~flush_o;
	wire sk = tk && instr_i[11:8] == 4'h7;
	wire ca = tk && instr_i[11:8] == 4'h9;
	wire hi = file_data_i[instr_i[7:5]];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_skip; sk && hi |=> flush_o && pc_o == $past(pc_o) + 11'h002; endproperty
	a_skip: assert property (p_skip) else $error("taken skip wrong");
	property p_noskip; sk && !hi |=> !flush_o && pc_o == $past(pc_o) + 11'h001; endproperty
	a_noskip: assert property (p_noskip) else $error("untaken skip wrong");
	property p_req; sk |=> file_req_o == {1'b1, $past(instr_i[4:0]), $past(instr_i[7:5])}; endproperty
	a_req: assert property (p_req) else $error("operand fetch wrong");
	property p_push; ca |=> return_stack_top_o == {1'b1, $past(pc_o) + 11'h001}; endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_call; ca |=> pc_o == {$past(status_i[6:5]), 1'b0, $past(instr_i[7:0])}; endproperty
	a_call: assert property (p_call) else $error("call target wrong");
	property p_call2; ca |=> flush_o ##1 !flush_o; endproperty
	a_call2: assert property (p_call2) else $error("call length wrong");
	property p_hold; flush_o |=> pc_o == $past(pc_o) && !flush_o; endproperty
	a_hold: assert property (p_hold) else $error("flush cycle wrong");
	property p_nopush; sk |=> !return_stack_top_o.valid; endproperty
	a_nopush: assert property (p_nopush) else $error("skip pushed");
	c_skip: cover property (sk && hi);
	c_call: cover property (ca);
	c_refuse: cover property (flush_o && instr_valid_i);
endmodule
bind bsc_exec bsc_exec_chk u_chk (.*);

// file: test_bsc_exec.sv
// testbench for the bit-skip and call block
`timescale 1ns/100ps
module test_bsc_exec;
	logic                clk_i = 0, reset_n_i = 0, instr_valid_i = 0;
	logic [11:0]         instr_i = 12'h000;
	logic [7:0]          file_data_i = 8'h00, status_i = 8'h00;
	bsc_pkg::bsc_fetch_t file_req_o;
	bsc_pkg::bsc_push_t  return_stack_top_o;
	logic [10:0]         pc_o, pc = 11'h000;
	logic                flush_o, busy_o;
	int                  fails = 0, samples_checked = 0;
	bsc_exec u_bsc_exec
	(
		.clk_i              (clk_i),
		.reset_n_i          (reset_n_i),
		.instr_i            (instr_i),
		.instr_valid_i      (instr_valid_i),
		.file_data_i        (file_data_i),
		.status_i           (status_i),
		.file_req_o         (file_req_o),
		.return_stack_top_o (return_stack_top_o),
		.pc_o               (pc_o),
		.flush_o            (flush_o),
		.busy_o             (busy_o)
	);
	initial forever #12.5 clk_i = ~clk_i;
	task chk(input logic c);
		samples_checked++;
		if (c !== 1'b1)
		begin
			fails++;
			$display("Error %0t mismatch", $time);
		end
	endtask
	// k keeps valid up into the next cycle, used to offer a word during flush
	task go(input logic [11:0] w, input logic k, input logic [7:0] d, input logic [7:0] s);
		@(posedge clk_i);
		instr_i <= w;
		instr_valid_i <= 1'b1;
		file_data_i <= d;
		status_i <= s;
		@(posedge clk_i);
		instr_valid_i <= k;
		#1;
	endtask
	task t_noskip;
		go(12'h7FF, 1'b0, 8'h7F, 8'h00);
		pc = pc + 11'h001;
		chk(pc_o === pc && flush_o === 1'b0);
		chk(file_req_o === {1'b1, 5'h1F, 3'h7});
		$display("untaken skip done");
	endtask
	task t_skip;
		go(12'h700, 1'b1, 8'h01, 8'h00);
		pc = pc + 11'h002;
		chk(pc_o === pc && flush_o === 1'b1 && busy_o === 1'b1);
		chk(file_req_o === {1'b1, 5'h00, 3'h0});
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1;
		chk(pc_o === pc && flush_o === 1'b0);
		$display("taken skip done");
	endtask
	// other words step pc up to 0x100, so the call must really clear bit 8
	task t_step;
		repeat (253) go(12'h000, 1'b0, 8'h00, 8'h00);
		pc = pc + 11'h0FD;
		chk(pc_o === pc && pc_o === 11'h100 && flush_o === 1'b0);
		$display("step run done");
	endtask
	// page bits 01 among set neighbours, so a swap or a leak shows
	task t_call;
		go(12'h9A5, 1'b0, 8'h00, 8'hBF);
		chk(return_stack_top_o === {1'b1, pc + 11'h001});
		chk(pc_o === 11'h2A5 && flush_o === 1'b1);
		@(posedge clk_i);
		#1;
		chk(flush_o === 1'b0);
		$display("call done");
	endtask
	task finish_test;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		t_noskip;
		t_skip;
		t_step;
		t_call;
		finish_test;
	end
endmodule
